// >>> core/rotate_right_and_set_file_ops_regs.vh
/*
 Register map, field positions, reset values and opcode patterns of the
 byte rotate and set-file execution block.
 Assumes the includer takes it by bare name, once or more.
*/
`ifndef ROTATE_RIGHT_AND_SET_FILE_OPS_REGS_VH
`define ROTATE_RIGHT_AND_SET_FILE_OPS_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_INSTR 6'h00
`define OFS_STATUS 6'h04
`define OFS_WREG 6'h08
`define OFS_BANK 6'h0c
`define OFS_FADDR 6'h10
`define OFS_FDATA 6'h14

// ****************************************
// Status field positions
// ****************************************
`define ST_C 0
`define ST_Z 2
`define ST_N 4
`define ST_BUSY 8
`define ST_BAD 9

// ****************************************
// Reset values
// ****************************************
`define RST_INSTR 16'h0000
`define RST_BYTE 8'h00
`define RST_BANK 4'h0
`define RST_FADDR 12'h000

// ****************************************
// Opcode patterns and constants
// ****************************************
`define OP_RRC 6'h0c
`define OP_RRN 6'h10
`define OP_SET 7'h34
`define ALL_ONES 8'hff
`define ACC_HI_BANK 4'hf
`define ACC_LO_BANK 4'h0

`endif

// >>> core/rotate_right_and_set_file_ops.v
/*
 Execution logic for three byte instructions: rotate right through carry,
 rotate right without carry and set file to all ones, with its data memory,
 accumulator, bank select and flags, all reached over an AXI4-Lite slave.
 Assumes one 200 MHz clock, a synchronous active-low reset and a master
 that keeps AXI4-Lite handshake rules.
*/
// The address map and the AXI4-Lite interface to the registers were decided locally.
// Summary of operation
// RULE1 - Rotate-through-carry opcode 001100da: bit0 to carry, old carry to bit7; C,N,Z.
// RULE2 - Plain rotate moves bit n to n-1, bit 0 to bit 7, carry kept.
// RULE3 - Plain rotate updates only negative and zero from its result.
// RULE4 - Plain rotate is decoded from 010000, destination, access and file address.
// RULE5 - Rotates: destination 0 writes accumulator, destination 1 writes file register.
// RULE6 - Access 0 uses the access bank; access 1 uses the bank select value.
// RULE7 - Set-file writes ff into the addressed file register.
// RULE8 - Set-file decoded from 0110100a plus address; no destination, no flags.
// RULE9 - File address is eight bits, 0 to 255 within the selected bank.
// RULE10 - One word, one cycle: decode, read, process, write destination. The code spends one clock on each phase, four clocks in all.
`timescale 1ns/10ps
`include "rotate_right_and_set_file_ops_regs.vh"

module rotate_right_and_set_file_ops
(
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Write address channel
	input wire [31:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// Write data channel
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// Write response channel
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// Read address channel
	input wire [31:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// Read data channel
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	localparam [2:0] S_IDLE = 3'd0;
	localparam [2:0] S_DECODE = 3'd1;
	localparam [2:0] S_READ = 3'd2;
	localparam [2:0] S_PROC = 3'd3;
	localparam [2:0] S_WRITE = 3'd4;

	// ****************************************
	// State
	// ****************************************
	reg [7:0] mem [0:4095];
	reg [2:0] st_q;
	reg [15:0] instr_q;
	reg [7:0] wreg_q;
	reg [3:0] bank_q;
	reg [11:0] faddr_q;
	reg c_q;
	reg z_q;
	reg n_q;
	reg bad_q;
	reg [1:0] kind_q;
	reg dest_q;
	reg [11:0] eaddr_q;
	reg [7:0] opnd_q;
	reg [7:0] res_q;
	reg res_c_q;
	reg aw_q;
	reg w_q;
	reg [31:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;

	localparam [1:0] K_RRC = 2'd0;
	localparam [1:0] K_RRN = 2'd1;
	localparam [1:0] K_SET = 2'd2;
	localparam [1:0] K_BAD = 2'd3;

	wire busy = (st_q != S_IDLE);

	// ****************************************
	// Bus write side
	// ****************************************
	assign s_axi_awready = !aw_q && !s_axi_bvalid;
	assign s_axi_wready = !w_q && !s_axi_bvalid;

	wire aw_now = aw_q || (s_axi_awvalid && s_axi_awready);
	wire w_now = w_q || (s_axi_wvalid && s_axi_wready);
	wire [31:0] wa = aw_q ? awaddr_q : s_axi_awaddr;
	wire [31:0] wd = w_q ? wdata_q : s_axi_wdata;
	wire [3:0] ws = w_q ? wstrb_q : s_axi_wstrb;
	wire do_wr = aw_now && w_now && !s_axi_bvalid;
	wire wr_hit = (wa[31:6] == 26'h0) && (wa[1:0] == 2'b00)
		&& (wa[5:0] <= `OFS_FDATA);
	// Writes while an instruction runs are dropped but still answered OKAY,
	// so the memory and registers never see two writers in one cycle.
	wire wr_ok = do_wr && wr_hit && !busy;
	wire wr_instr = wr_ok && (wa[5:0] == `OFS_INSTR);
	wire wr_stat = wr_ok && (wa[5:0] == `OFS_STATUS) && ws[0];
	wire wr_w = wr_ok && (wa[5:0] == `OFS_WREG) && ws[0];
	wire wr_bank = wr_ok && (wa[5:0] == `OFS_BANK) && ws[0];
	wire wr_fa = wr_ok && (wa[5:0] == `OFS_FADDR);
	wire wr_fd = wr_ok && (wa[5:0] == `OFS_FDATA) && ws[0];

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 32'h0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
				awaddr_q <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready)
			begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_wr)
			begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
			end
			else
			begin
				aw_q <= aw_now;
				w_q <= w_now;
				if (s_axi_bvalid && s_axi_bready)
					s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// Bus read side
	// ****************************************
	assign s_axi_arready = !s_axi_rvalid;
	wire ar_go = s_axi_arvalid && s_axi_arready;
	wire rd_hit = (s_axi_araddr[31:6] == 26'h0) && (s_axi_araddr[1:0] == 2'b00)
		&& (s_axi_araddr[5:0] <= `OFS_FDATA);
	reg [31:0] rd_val;

	always @*
	begin
		rd_val = 32'h0;
		case (s_axi_araddr[5:0])
			`OFS_INSTR: rd_val = {16'h0, instr_q};
			`OFS_STATUS:
			begin
				rd_val[`ST_C] = c_q;
				rd_val[`ST_Z] = z_q;
				rd_val[`ST_N] = n_q;
				rd_val[`ST_BUSY] = busy;
				rd_val[`ST_BAD] = bad_q;
			end
			`OFS_WREG: rd_val = {24'h0, wreg_q};
			`OFS_BANK: rd_val = {28'h0, bank_q};
			`OFS_FADDR: rd_val = {20'h0, faddr_q};
			`OFS_FDATA: rd_val = {24'h0, mem[faddr_q]};
			default: rd_val = 32'h0;
		endcase
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'b00;
		end
		else if (ar_go)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_hit ? rd_val : 32'h0;
			s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ****************************************
	// Decode
	// ****************************************
	reg [1:0] kind_d;
	always @*
	begin
		if (instr_q[15:10] == `OP_RRC)
			kind_d = K_RRC; // [RULE1]
		else if (instr_q[15:10] == `OP_RRN)
			kind_d = K_RRN; // [RULE4]
		else if (instr_q[15:9] == `OP_SET)
			kind_d = K_SET; // [RULE8]
		else
			kind_d = K_BAD;
	end

	// The access bank splits at file address 80h: the low half maps to the
	// bottom bank and the high half to the top bank.
	wire [7:0] fa = instr_q[7:0]; // [RULE9]
	wire [11:0] eaddr_d = instr_q[8] ? {bank_q, fa}
		: {(fa[7] ? `ACC_HI_BANK : `ACC_LO_BANK), fa}; // [RULE6]

	// ****************************************
	// Four-phase execution
	// ****************************************
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_q <= S_IDLE;
			instr_q <= `RST_INSTR;
			kind_q <= K_BAD;
			dest_q <= 1'b0;
			eaddr_q <= `RST_FADDR;
			opnd_q <= `RST_BYTE;
			res_q <= `RST_BYTE;
			res_c_q <= 1'b0;
			wreg_q <= `RST_BYTE;
			bank_q <= `RST_BANK;
			faddr_q <= `RST_FADDR;
			c_q <= 1'b0;
			z_q <= 1'b0;
			n_q <= 1'b0;
			bad_q <= 1'b0;
		end
		else
		begin
			if (wr_w)
				wreg_q <= wd[7:0];
			if (wr_bank)
				bank_q <= wd[3:0];
			if (wr_fa)
				faddr_q <= wd[11:0];
			if (wr_stat)
			begin
				c_q <= wd[`ST_C];
				z_q <= wd[`ST_Z];
				n_q <= wd[`ST_N];
				bad_q <= wd[`ST_BAD];
			end
			case (st_q)
				S_IDLE:
				begin
					if (wr_instr)
					begin
						instr_q <= wd[15:0];
						st_q <= S_DECODE;
					end
				end
				S_DECODE:
				begin
					kind_q <= kind_d; // [RULE10]
					dest_q <= instr_q[9];
					eaddr_q <= eaddr_d;
					bad_q <= (kind_d == K_BAD);
					st_q <= S_READ;
				end
				S_READ:
				begin
					opnd_q <= mem[eaddr_q]; // [RULE10]
					st_q <= S_PROC;
				end
				S_PROC:
				begin
					res_c_q <= (kind_q == K_RRC) ? opnd_q[0] : c_q; // [RULE1]
					case (kind_q)
						K_RRC: res_q <= {c_q, opnd_q[7:1]}; // [RULE1]
						K_RRN: res_q <= {opnd_q[0], opnd_q[7:1]}; // [RULE2]
						K_SET: res_q <= `ALL_ONES; // [RULE7]
						default: res_q <= opnd_q;
					endcase
					st_q <= S_WRITE;
				end
				S_WRITE:
				begin
					if (kind_q == K_RRC || kind_q == K_RRN)
					begin
						if (!dest_q)
							wreg_q <= res_q; // [RULE5]
						z_q <= (res_q == 8'h00); // [RULE3]
						n_q <= res_q[7];
					end
					if (kind_q == K_RRC)
						c_q <= res_c_q; // [RULE1]
					st_q <= S_IDLE;
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// ****************************************
	// File memory, one write port
	// ****************************************
	// Bus writes are blocked while busy, so the two writers never collide.
	wire ex_wr = (st_q == S_WRITE)
		&& (kind_q == K_SET || ((kind_q != K_BAD) && dest_q)); // [RULE5]

	always @(posedge aclk)
	begin
		if (ex_wr)
			mem[eaddr_q] <= res_q; // [RULE7]
		else if (wr_fd)
			mem[faddr_q] <= wd[7:0];
	end

endmodule

// >>> sim/rotate_ops_monitor.sv
/* Bus protocol checker for the byte rotate block.
 Assumes it is bound to the block and sees only its ports. */
`timescale 1ns/10ps
// ****************
// Bus checker
// ****************
module rotate_ops_monitor
(
	// Clock and reset
	input logic aclk,
	input logic aresetn,
	// Write channels
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	// Read channels
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic [1:0] s_axi_rresp,
	input logic s_axi_rvalid,
	input logic s_axi_rready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_b_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("Write response dropped early.");
	a_r_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("Read data dropped early.");
	a_w_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("Write not answered in one cycle.");
	a_r_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("Read not answered in one cycle.");
	a_ar_block: assert property (
		s_axi_rvalid |-> !s_axi_arready)
		else $error("Read taken while one is pending.");
	a_aw_block: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("Write taken while one is pending.");
	a_b_done: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("Write response repeated.");
	a_err_data: assert property (
		s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("Error read carries data.");
	a_reset_idle: assert property (disable iff (1'b0)
		!aresetn |=> !s_axi_bvalid && !s_axi_rvalid && s_axi_arready)
		else $error("Bus not idle after reset.");
	c_err_read: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind rotate_right_and_set_file_ops rotate_ops_monitor rotate_ops_monitor_i (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready);

// >>> sim/testbench.sv
/* Self-checking bench for the byte rotate block.
 Assumes the block's AXI4-Lite slave and its register header. */
`timescale 1ns/10ps
`include "rotate_right_and_set_file_ops_regs.vh"
// ****************
// Bench
// ****************
module testbench;
	typedef struct {logic [15:0] ins, bk, ix, s0, m0, w0, m1, w1, s1;} row_t;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
	logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] v;
	row_t rows [0:6];
	integer fails = 0, samples_checked = 0, stall = 0, n, i;
	always #2.5 aclk = ~aclk;
	rotate_right_and_set_file_ops rotate_right_and_set_file_ops_i (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	task give_verdict;
		begin
			if (fails == 0 && samples_checked > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	task chk(input [31:0] g, input [31:0] e);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e)
			begin
				fails = fails + 1;
				$display("ERROR at %0t: got %h, expected %h", $time, g, e);
			end
		end
	endtask
	// A nonzero stall holds the response ready back, so the slave must keep its answer.
	task wr(input [5:0] a, input [15:0] d);
		begin
			s_axi_awaddr <= {26'h0, a};
			s_axi_wdata <= {16'h0, d};
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= (stall == 0);
			n = 0;
			do
			begin
				@(posedge aclk);
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
				n = n + 1;
				if (n >= stall) s_axi_bready <= 1'b1;
			end
			while (!(s_axi_bvalid && s_axi_bready));
			// Ready stays up after the answer, so a following call never flips it twice at once.
			resp = s_axi_bresp;
		end
	endtask
	task rd(input [5:0] a);
		begin
			s_axi_araddr <= {26'h0, a};
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= (stall == 0);
			n = 0;
			do
			begin
				@(posedge aclk);
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
				n = n + 1;
				if (n >= stall) s_axi_rready <= 1'b1;
			end
			while (!(s_axi_rvalid && s_axi_rready));
			v = s_axi_rdata;
			resp = s_axi_rresp;
		end
	endtask
	task rdc(input [5:0] a, input [15:0] e);
		begin
			rd(a);
			chk(v, {16'h0, e});
		end
	endtask
	initial
	begin
		rows[0] = '{16'h3312, 16'h3, 16'h312, 16'h1, 16'he6, 16'h0, 16'hf3, 16'h0, 16'h10};
		rows[1] = '{16'h3020, 16'h0, 16'h20, 16'h0, 16'h1, 16'h55, 16'h1, 16'h0, 16'h5};
		rows[2] = '{16'h4290, 16'h5, 16'hf90, 16'h1, 16'hd7, 16'h33, 16'heb, 16'h33, 16'h11};
		rows[3] = '{16'h4105, 16'h7, 16'h705, 16'h0, 16'hd7, 16'h0, 16'hd7, 16'heb, 16'h10};
		rows[4] = '{16'h69ff, 16'h2, 16'h2ff, 16'h15, 16'h5a, 16'h11, 16'hff, 16'h11, 16'h15};
		rows[5] = '{16'h687f, 16'h9, 16'h7f, 16'h0, 16'h0, 16'h0, 16'hff, 16'h0, 16'h0};
		rows[6] = '{16'h4300, 16'hf, 16'hf00, 16'h1, 16'h0, 16'h0, 16'h0, 16'h0, 16'h5};
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 5; i++) rdc(6'(i * 4), 16'h0);
		for (i = 0; i < 7; i++)
		begin
			wr(`OFS_BANK, rows[i].bk);
			wr(`OFS_FADDR, rows[i].ix);
			wr(`OFS_FDATA, rows[i].m0);
			wr(`OFS_WREG, rows[i].w0);
			wr(`OFS_STATUS, rows[i].s0);
			wr(`OFS_INSTR, rows[i].ins);
			rd(`OFS_STATUS);
			chk({31'h0, v[8]}, 32'h1);
			repeat (2) rd(`OFS_STATUS);
			chk(v, {16'h0, rows[i].s1});
			rdc(`OFS_WREG, rows[i].w1);
			rdc(`OFS_FDATA, rows[i].m1);
		end
		for (i = 0; i < 2; i++)
		begin
			wr(`OFS_FADDR, 16'h7f);
			wr(`OFS_FDATA, 16'h3c);
			wr(`OFS_INSTR, i ? 16'h347f : 16'h6a7f);
			repeat (3) rd(`OFS_STATUS);
			chk(v, 32'h205);
			rdc(`OFS_FDATA, 16'h3c);
		end
		stall = 3;
		rd(6'h18);
		chk({resp, v[29:0]}, 32'h80000000);
		wr(6'h1c, 16'h1);
		chk({30'h0, resp}, 32'h2);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		stall = 0;
		for (i = 0; i < 5; i++) rdc(6'(i * 4), 16'h0);
		give_verdict;
	end
	initial
	begin
		#20000;
		fails = fails + 1;
		give_verdict;
	end
endmodule
